//--- common/scan_sel_pkg.sv
// Purpose: Shared constants and types for the multidrop scan select block.
// Assumes: Backplane test clock is sampled by the 25 MHz system clock.
// Notes:   Instruction codes other than the return and group select codes are not decoded here.
package scan_sel_pkg;

  // ****************************************************************
  // Instruction register and address codes
  // ****************************************************************
  localparam int          IR_WIDTH        = 8;
  localparam int          ADDR_WIDTH      = 6;
  localparam int          ID_WIDTH        = 32;
  localparam int          GROUP_WIDTH     = 2;
  localparam logic [5:0]  BROADCAST_ADDR  = 6'h3B;
  localparam logic [5:0]  MULTICAST_BASE  = 6'h3C;
  localparam logic [3:0]  MULTICAST_HI    = 4'hF;
  localparam logic [7:0]  RETURN_WAIT_OP  = 8'hC3;
  localparam logic [7:0]  GROUP_SEL_OP    = 8'h03;
  localparam logic [7:0]  IR_RESET_VAL    = 8'h00;
  localparam logic [1:0]  GROUP_RESET_VAL = 2'h0;
  // Identification value is arbitrary and names no real part.
  localparam logic [31:0] ID_VALUE        = 32'h12345001;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Standard sixteen-state test access port controller.
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
    TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  // Level-1 selection machine.
  typedef enum logic [1:0] {
    SEL_WAIT, SEL_SINGLE, SEL_GROUP, SEL_NONE
  } sel_state_t;

  // Backplane pins after synchronisation.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bp_pins_t;

endpackage

//--- src/pin_sync.sv
// Purpose: Two-stage synchroniser for the backplane input pins.
// Assumes: Pins are asynchronous to clk.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module pin_sync
  import scan_sel_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire bp_pins_t pins_async,
  output bp_pins_t      pins_sync
);

  bp_pins_t meta_reg;
  bp_pins_t meta_next;
  bp_pins_t sync_reg;
  bp_pins_t sync_next;

  // Next values are simply the previous stage.
  always_comb begin
    meta_next = pins_async;
    sync_next = meta_reg;
  end

  // Register both stages.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pins_sync = sync_reg;

endmodule

//--- src/scan_address_select.sv
// Purpose: Level-1 address selection behind the backplane test port.
// Assumes: Backplane clock is far slower than clk; slot inputs are static.
// Notes:   Shifting happens on sampled rising edges, output on falling.
//
// Summary of operation
// - Reset leaves selection waiting for address.
// - Unselected shifting discards bits, output off.
// - Update compares six IR bits, slot, codes.
// - Match enters single or group selected state.
// - No match enters unselected state.
// - Chained registers shift in at MSB.
// - Address compares ignore upper two scanned bits.
// - Reset state or return instruction waits.
// - Selection puts identification register in chain.
// - Unselected ignores addresses until reset or return.
// - Broadcast selects all waiting; output stays off.
// - Group register holds one of four groups.
// - Multicast selects matching group; output off.
// - Group selected follows protocol, output off.
`timescale 1ns/1ps
module scan_address_select
  import scan_sel_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        backplane_clock,
  input  wire logic        backplane_mode,
  input  wire logic        backplane_serial_in,
  input  wire logic [5:0]  slot_addr,
  output logic             backplane_serial_out,
  output logic             backplane_serial_oe,
  output logic [1:0]       selection,
  output logic [1:0]       group_assign,
  output logic [7:0]       instr
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  bp_pins_t pins_async;
  bp_pins_t pins;

  assign pins_async = '{tck: backplane_clock, tms: backplane_mode,
                        tdi: backplane_serial_in};

  pin_sync u_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .pins_async (pins_async),
    .pins_sync  (pins)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic          tck_d_reg,   tck_d_next;
  logic [5:0]    slot1_reg,   slot1_next;
  logic [5:0]    slot_reg,    slot_next;
  logic          lvl2_reg,    lvl2_next;
  tap_state_t    tap_reg,     tap_next;
  sel_state_t    sel_reg,     sel_next;
  logic [7:0]    ir_sh_reg,   ir_sh_next;
  logic [7:0]    ir_reg,      ir_next;
  logic [31:0]   dr_sh_reg,   dr_sh_next;
  logic [1:0]    grp_reg,     grp_next;
  logic          tdo_reg,     tdo_next;
  logic          oe_reg,      oe_next;
  logic          rise;
  logic          fall;
  logic [5:0]    scan_addr;
  logic          is_group_code;
  logic          addr_match;
  logic          group_match;
  logic          selected;
  logic          grp_path;

  assign rise          = pins.tck & ~tck_d_reg;
  assign fall          = ~pins.tck & tck_d_reg;
  assign scan_addr     = ir_sh_reg[5:0];
  assign is_group_code = (scan_addr[5:2] == MULTICAST_HI);
  assign addr_match    = (scan_addr == slot_reg);
  assign group_match   = is_group_code &&
                         (scan_addr[1:0] == grp_reg);
  assign selected      = (sel_reg == SEL_SINGLE) ||
                         (sel_reg == SEL_GROUP);
  assign grp_path      = selected && lvl2_reg && (ir_reg == GROUP_SEL_OP);

  // Test access port controller advanced on each sampled rising edge.
  always_comb begin
    tap_next = tap_reg;
    if (rise) begin
      case (tap_reg)
        TAP_RESET:    tap_next = pins.tms ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:     tap_next = pins.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:   tap_next = pins.tms ? TAP_SEL_IR   : TAP_CAP_DR;
        TAP_CAP_DR:   tap_next = pins.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: tap_next = pins.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: tap_next = pins.tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
        TAP_PAUSE_DR: tap_next = pins.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: tap_next = pins.tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
        TAP_UPD_DR:   tap_next = pins.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:   tap_next = pins.tms ? TAP_RESET    : TAP_CAP_IR;
        TAP_CAP_IR:   tap_next = pins.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: tap_next = pins.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: tap_next = pins.tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
        TAP_PAUSE_IR: tap_next = pins.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: tap_next = pins.tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
        TAP_UPD_IR:   tap_next = pins.tms ? TAP_SEL_DR   : TAP_IDLE;
        default:      tap_next = TAP_RESET;
      endcase
    end
  end

  // Instruction shift and hold registers; update takes effect on fall.
  always_comb begin
    ir_sh_next = ir_sh_reg;
    ir_next    = ir_reg;
    if (tap_reg == TAP_RESET) begin
      ir_next = IR_RESET_VAL;
    end else if (rise && tap_reg == TAP_CAP_IR) begin
      ir_sh_next = {6'h00, 2'h1};
    end else if (rise && tap_reg == TAP_SHIFT_IR) begin
      // New bit at the top, bottom bit leaves the register.
      ir_sh_next = {pins.tdi, ir_sh_reg[7:1]};
    end else if (fall && tap_reg == TAP_UPD_IR) begin
      ir_next = ir_sh_reg;
    end
  end

  // Level-1 selection machine, evaluated at the update of the instruction.
  // While waiting every scanned value is an address with its two upper
  // bits ignored, so the return code only acts once selected or unselected.
  always_comb begin
    sel_next  = sel_reg;
    lvl2_next = lvl2_reg;
    if (tap_reg == TAP_RESET) begin
      sel_next  = SEL_WAIT;
      lvl2_next = 1'b0;
    end else if (fall && tap_reg == TAP_UPD_IR) begin
      // Only an update made while selected loads a real instruction.
      lvl2_next = selected;
      if (sel_reg == SEL_WAIT) begin
        if (scan_addr == BROADCAST_ADDR) begin
          sel_next = SEL_GROUP;
        end else if (group_match) begin
          sel_next = SEL_GROUP;
        end else if (!is_group_code && addr_match) begin
          sel_next = SEL_SINGLE;
        end else begin
          sel_next = SEL_NONE;
        end
      end else if (ir_sh_reg == RETURN_WAIT_OP) begin
        sel_next = SEL_WAIT;
      end
      // Unselected stays put until reset or the return code.
    end
  end

  // Data path: group register when chosen, else identification value.
  always_comb begin
    dr_sh_next = dr_sh_reg;
    grp_next   = grp_reg;
    if (tap_reg == TAP_RESET) begin
      grp_next = GROUP_RESET_VAL;
    end else if (rise && tap_reg == TAP_CAP_DR) begin
      if (grp_path) begin
        dr_sh_next = {30'h0, grp_reg};
      end else begin
        dr_sh_next = ID_VALUE;
      end
    end else if (rise && tap_reg == TAP_SHIFT_DR) begin
      if (grp_path) begin
        dr_sh_next = {30'h0, pins.tdi, dr_sh_reg[1]};
      end else begin
        dr_sh_next = {pins.tdi, dr_sh_reg[31:1]};
      end
    end else if (fall && tap_reg == TAP_UPD_DR && grp_path &&
                 sel_reg == SEL_SINGLE) begin
      grp_next = dr_sh_reg[1:0];
    end
  end

  // Serial output changes on the falling edge while shifting.
  always_comb begin
    tdo_next = tdo_reg;
    oe_next  = oe_reg;
    if (fall) begin
      oe_next = 1'b0;
      if (sel_reg == SEL_SINGLE &&
          (tap_reg == TAP_SHIFT_IR || tap_reg == TAP_SHIFT_DR)) begin
        oe_next  = 1'b1;
        tdo_next = (tap_reg == TAP_SHIFT_IR) ? ir_sh_reg[0]
                                             : dr_sh_reg[0];
      end
      // Group selection and unselected keep the output off.
    end
    if (sel_reg != SEL_SINGLE) begin
      oe_next = 1'b0;
    end
  end

  // Register all state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tck_d_reg <= 1'b0;
      slot1_reg <= 6'h00;
      slot_reg  <= 6'h00;
      lvl2_reg  <= 1'b0;
      tap_reg   <= TAP_RESET;
      sel_reg   <= SEL_WAIT;
      ir_sh_reg <= IR_RESET_VAL;
      ir_reg    <= IR_RESET_VAL;
      dr_sh_reg <= '0;
      grp_reg   <= GROUP_RESET_VAL;
      tdo_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      tck_d_reg <= pins.tck;
      slot1_reg <= slot1_next;
      slot_reg  <= slot_next;
      lvl2_reg  <= lvl2_next;
      tap_reg   <= tap_next;
      sel_reg   <= sel_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg    <= ir_next;
      dr_sh_reg <= dr_sh_next;
      grp_reg   <= grp_next;
      tdo_reg   <= tdo_next;
      oe_reg    <= oe_next;
    end
  end

  // Slot pins come from outside; two register stages guard against
  // metastability if they are ever strapped while the clock runs.
  assign slot1_next = slot_addr;
  assign slot_next  = slot1_reg;

  assign backplane_serial_out = tdo_reg;
  assign backplane_serial_oe  = oe_reg;
  assign selection            = sel_reg;
  assign group_assign         = grp_reg;
  assign instr                = ir_reg;

endmodule

//--- bench/scan_address_select_monitor.sv
// Purpose: Concurrent checks on the selection block's ports.
// Assumes: instr shows the updated instruction, not the shift stage.
// Notes:   Bound to every instance of the selection block.
`timescale 1ns/1ps
module scan_address_select_monitor
  import scan_sel_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [5:0] slot_addr,
  input wire logic       backplane_serial_oe,
  input wire logic [1:0] selection,
  input wire logic [1:0] group_assign,
  input wire logic [7:0] instr
);
  // ****************************************************************
  // Selection and output enable checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_waits: assert property (
    $rose(reset_n) |-> selection == SEL_WAIT)
    else $error("selection not waiting after reset");
  a_return_waits: assert property (
    $changed(instr) && instr == RETURN_WAIT_OP &&
    $past(selection) != SEL_WAIT |-> selection == SEL_WAIT)
    else $error("return code ignored");
  a_none_sticky: assert property (
    (selection == SEL_NONE) ##1 (selection != SEL_NONE) |->
    selection == SEL_WAIT)
    else $error("unselected left to a selected state");
  a_single_slot: assert property (
    $changed(selection) && selection == SEL_SINGLE |->
    instr[5:0] == slot_addr)
    else $error("single select without slot match");
  a_group_code: assert property (
    $changed(selection) && selection == SEL_GROUP |->
    instr[5:0] == BROADCAST_ADDR ||
    instr[5:0] == {MULTICAST_HI, group_assign})
    else $error("group select without group code");
  a_miss_none: assert property (
    $past(selection) == SEL_WAIT && selection == SEL_NONE |->
    instr[5:0] != slot_addr)
    else $error("unselected despite slot match");
  a_from_wait: assert property (
    $changed(selection) && selection != SEL_WAIT |->
    $past(selection) == SEL_WAIT)
    else $error("selected without waiting first");
  a_oe_single: assert property (
    backplane_serial_oe |-> selection == SEL_SINGLE)
    else $error("serial out driven when not single");
endmodule
bind scan_address_select scan_address_select_monitor i_monitor (
  .clk(clk), .reset_n(reset_n), .slot_addr(slot_addr),
  .backplane_serial_oe(backplane_serial_oe), .selection(selection),
  .group_assign(group_assign), .instr(instr));

//--- bench/scan_tester_model.sv
// Purpose: Behavioural backplane test controller.
// Assumes: One test clock period is eight system clock cycles.
// Notes:   A released serial line reads as a toggling pattern.
`timescale 1ns/1ps
module scan_tester_model (
  input  wire logic clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  // ****************************************************************
  // Test clock and scan tasks
  // ****************************************************************
  logic last = 1'b0;
  // Pins idle low clock, mode high, so the port rests in reset.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock period; the line is sampled just before the fall.
  task automatic clk_bit(input logic m, input logic d, output logic s);
    @(posedge clk);
    s = tdo_oe ? tdo : ~last;
    last = s;
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Five mode-high clocks reach reset, then one more reaches idle.
  task automatic tap_reset();
    logic s;
    repeat (5) clk_bit(1'b1, 1'b0, s);
    clk_bit(1'b0, 1'b0, s);
  endtask
  // Scans n bits LSB first from idle and returns to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] v,
                      output logic [31:0] q);
    logic s;
    q = '0;
    clk_bit(1'b1, 1'b0, s);
    if (ir) clk_bit(1'b1, 1'b0, s);
    clk_bit(1'b0, 1'b0, s);
    clk_bit(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      clk_bit(i == n - 1, v[i], s);
      if (i > 0) q[i-1] = s;
    end
    clk_bit(1'b1, 1'b0, s);
    q[n-1] = s;
    clk_bit(1'b0, 1'b0, s);
  endtask
endmodule

//--- bench/multidrop_scan_address_select_tb_top.sv
// Purpose: Self-checking bench for the selection block.
// Assumes: Slot address is static after the first cycle.
// Notes:   Expected values queue up; a watcher compares them.
`timescale 1ns/1ps
module multidrop_scan_address_select_tb_top
  import scan_sel_pkg::*;
;
  // ****************************************************************
  // Signals, instances and checking
  // ****************************************************************
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  slot_addr = 6'h00;
  logic        tck, tms, tdi, so, oe;
  logic [1:0]  selection, group_assign;
  logic [7:0]  instr;
  logic [31:0] rd;
  logic        done = 1'b0;
  int          kind = 0;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] exp_q[$];
  string       name_q[$];
  always #20 clk = ~clk;
  scan_tester_model i_scan_tester_model (.clk(clk), .tdo(so), .tdo_oe(oe),
    .tck(tck), .tms(tms), .tdi(tdi));
  scan_address_select i_scan_address_select (.clk(clk), .reset_n(reset_n),
    .backplane_clock(tck), .backplane_mode(tms), .backplane_serial_in(tdi),
    .slot_addr(slot_addr), .backplane_serial_out(so),
    .backplane_serial_oe(oe), .selection(selection),
    .group_assign(group_assign), .instr(instr));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One compare task for each kind of result.
  task automatic cmp_selection(input string nm, input logic [31:0] e);
    cmp(nm, e, {30'h0, selection});
  endtask
  task automatic cmp_group(input string nm, input logic [31:0] e);
    cmp(nm, e, {30'h0, group_assign});
  endtask
  task automatic cmp_id(input string nm, input logic [31:0] e);
    cmp(nm, e, rd);
  endtask
  // Queues an expectation and flags the watcher once outputs settle.
  task automatic note(input string nm, input int k, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    repeat (8) @(posedge clk);
    kind <= k;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic addr(input logic [7:0] a, input sel_state_t e);
    logic [31:0] q;
    i_scan_tester_model.scan(1'b1, 8, {24'h0, a}, q);
    note("selection", 0, {30'h0, e});
  endtask
  // The watcher takes the oldest expectation for each flagged result.
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (kind == 0) begin
        cmp_selection(name_q.pop_front(), exp_q.pop_front());
      end else if (kind == 1) begin
        cmp_group(name_q.pop_front(), exp_q.pop_front());
      end else begin
        cmp_id(name_q.pop_front(), exp_q.pop_front());
      end
    end
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Main sequence of scenarios.
  initial begin
    logic [31:0] q;
    logic [1:0]  g;
    logic [5:0]  a;
    void'($urandom(32'hD913));
    slot_addr <= 6'($urandom_range(58, 0));
    g = 2'($urandom);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    note("selection", 0, {30'h0, SEL_WAIT});
    i_scan_tester_model.tap_reset();
    addr({2'($urandom), slot_addr}, SEL_SINGLE);
    i_scan_tester_model.scan(1'b0, 32, $urandom, rd);
    note("id", 2, ID_VALUE);
    addr(GROUP_SEL_OP, SEL_SINGLE);
    i_scan_tester_model.scan(1'b0, 2, {30'h0, g}, q);
    note("group", 1, {30'h0, g});
    addr(RETURN_WAIT_OP, SEL_WAIT);
    addr({2'($urandom), BROADCAST_ADDR}, SEL_GROUP);
    i_scan_tester_model.scan(1'b0, 32, $urandom, q);
    addr(RETURN_WAIT_OP, SEL_WAIT);
    for (int k = 0; k < 4; k++) begin
      a = MULTICAST_BASE + 6'(k);
      addr({2'($urandom), a}, 2'(k) == g ? SEL_GROUP : SEL_NONE);
      if (2'(k) != g) addr({2'h0, slot_addr}, SEL_NONE);
      addr(RETURN_WAIT_OP, SEL_WAIT);
    end
    addr({2'h1, slot_addr}, SEL_SINGLE);
    i_scan_tester_model.scan(1'b0, 32, $urandom, rd);
    note("id", 2, ID_VALUE);
    addr(RETURN_WAIT_OP, SEL_WAIT);
    a = slot_addr == 6'h00 ? 6'h01 : slot_addr - 6'h01;
    addr({2'h2, a}, SEL_NONE);
    i_scan_tester_model.tap_reset();
    note("selection", 0, {30'h0, SEL_WAIT});
    note("group", 1, {30'h0, GROUP_RESET_VAL});
    report_and_stop();
  end
endmodule
